// >>> design/sac_defs.svh
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

// Data space addresses
`define SAC_RES_OFF      8'hD0
`define SAC_CTRL_OFF     8'hD1

// Control register layout and reset value
`define SAC_CTRL_RST     8'h40
`define SAC_IRQ_EN_BIT   7
`define SAC_EOC_BIT      6
`define SAC_START_BIT    5
`define SAC_POWER_BIT    4
`define SAC_UNUSED_HI    3

// Result width and first trial code
`define SAC_RES_BITS     8
`define SAC_TRIAL_FIRST  8'h80
`define SAC_MSB_IDX      3'h7
`define SAC_ZERO8        8'h00

// Conversion timing
`define SAC_OSC_DIV      12
`define SAC_CONV_TIME_NS 70000
`define SAC_REF_OSC_KHZ  8000
`define SAC_NS_PER_MS    1000000
`define SAC_BIT_TICKS    ((`SAC_CONV_TIME_NS * `SAC_REF_OSC_KHZ / `SAC_NS_PER_MS / `SAC_OSC_DIV) / `SAC_RES_BITS)

`endif

// >>> design/sac_pkg.sv
package sac_pkg;

	// Sequencer states
	typedef enum logic [0:0] {
		SAC_IDLE,
		SAC_RUN
	} sac_state_t;

	// Address match, shared by every register decode
	function automatic logic sac_hit(input logic [7:0] addr, input logic [7:0] off);
		sac_hit = (addr == off);
	endfunction : sac_hit

	// One-hot weight of a result bit
	function automatic logic [7:0] sac_bit_mask(input logic [2:0] idx);
		sac_bit_mask = 8'h01 << idx;
	endfunction : sac_bit_mask

endpackage : sac_pkg

// >>> design/sac_ifc.sv
`timescale 1ns/10ps
`default_nettype none

interface sac_ifc;
	logic       start;
	logic       power;
	logic       cmp;
	logic       busy;
	logic       done;
	logic [7:0] result;
	logic [7:0] trial;

	modport ctrl (output start, output power, output cmp,
		input busy, input done, input result, input trial);
	modport seq (input start, input power, input cmp,
		output busy, output done, output result, output trial);
endinterface : sac_ifc

`default_nettype wire

// >>> design/sac_seq.sv
`timescale 1ns/10ps
`default_nettype none
`include "sac_defs.svh"

module sac_seq
	import sac_pkg::*;
#(
	parameter int DIV       = `SAC_OSC_DIV,
	parameter int BIT_TICKS = `SAC_BIT_TICKS // R15
) (
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	sac_ifc.seq       bus
);

	localparam int PW    = (DIV > 1) ? $clog2(DIV) : 1;
	localparam int TW    = $clog2(BIT_TICKS + 1);
	localparam int TOTAL = `SAC_RES_BITS * BIT_TICKS * DIV;
	localparam logic [PW-1:0] PRE_LAST  = PW'(DIV - 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(BIT_TICKS - 1);

	// Elaboration checks
	if (DIV < 2) begin : g_div_chk
		$error("sac_seq: DIV must be at least 2");
	end
	if (BIT_TICKS < 1) begin : g_tick_chk
		$error("sac_seq: BIT_TICKS must be at least 1");
	end

	sac_state_t state_reg;
	logic [PW-1:0] pre_reg;
	logic [TW-1:0] tick_reg;
	logic [2:0]    bit_reg;
	logic [7:0]    sar_reg;
	logic [7:0]    result_reg;
	logic          done_reg;

	// Step decode: divided conversion clock and bit boundaries
	wire       conv_tick = (pre_reg == PRE_LAST); // R1
	wire       bit_end   = conv_tick && (tick_reg == TICK_LAST);
	wire       last_bit  = (bit_reg == 3'h0);
	wire [7:0] decided   = bus.cmp ? sar_reg : (sar_reg & ~sac_bit_mask(bit_reg)); // R19
	wire [7:0] next_try  = decided | sac_bit_mask(bit_reg - 3'h1); // R19
	wire       restart   = bus.start && bus.power;

	assign bus.busy   = (state_reg == SAC_RUN);
	assign bus.done   = done_reg;
	assign bus.result = result_reg;
	assign bus.trial  = sar_reg;

	// Successive approximation, most significant bit first
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg  <= SAC_IDLE; // R13
			pre_reg    <= '0;
			tick_reg   <= '0;
			bit_reg    <= `SAC_MSB_IDX;
			sar_reg    <= `SAC_ZERO8;
			result_reg <= `SAC_ZERO8;
			done_reg   <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (restart) begin
				// Abandon whatever runs and begin again
				state_reg <= SAC_RUN; // R2 R5
				pre_reg   <= '0;
				tick_reg  <= '0;
				bit_reg   <= `SAC_MSB_IDX;
				sar_reg   <= `SAC_TRIAL_FIRST;
			end else if (bus.busy && !bus.power) begin
				state_reg <= SAC_IDLE; // R10
			end else if (bus.busy) begin
				pre_reg <= conv_tick ? '0 : pre_reg + 1'b1; // R1
				if (conv_tick) begin
					tick_reg <= bit_end ? '0 : tick_reg + 1'b1;
				end
				if (bit_end && last_bit) begin
					state_reg  <= SAC_IDLE; // R4
					sar_reg    <= decided;
					result_reg <= decided; // R14
					done_reg   <= 1'b1; // R3
				end else if (bit_end) begin
					sar_reg <= next_try; // R19
					bit_reg <= bit_reg - 3'h1;
				end
			end
		end
	end

	// Helper: cycles spent since the last start
	logic [15:0] run_cnt;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_cnt <= '0;
		end else if (restart) begin
			run_cnt <= '0;
		end else if (bus.busy) begin
			run_cnt <= run_cnt + 16'h0001;
		end
	end

	a_conv_length: assert property ( // R1 R15
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		done_reg |-> (run_cnt == 16'(TOTAL)))
		else $error("conversion length wrong");

	a_msb_first: assert property ( // R19
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(bus.busy && bus.power && !bus.start && bit_end && !last_bit)
		|=> (bit_reg == $past(bit_reg) - 3'h1) && sar_reg[bit_reg])
		else $error("trial bit order wrong");

endmodule : sac_seq

`default_nettype wire

// >>> design/sac_top.sv
// Operation
// R1: Sequencer steps on the oscillator divided by twelve, successive approximation.
// R2: Writing one to start begins a conversion and clears done at once; the code keeps done set if completion falls in the same cycle.
// R3: Finishing a conversion sets done, marking the result as valid.
// R4: Single shot: after finishing, stay idle until start is written again.
// R5: Start written during a conversion abandons it and begins a fresh one.
// R6: Start bit is write only and always reads back as zero.
// R7: Done raises the vector 4 interrupt request only when enable is one.
// R8: Control bits: 7 enable, 6 done, 5 start, 4 power, 3..0 unused.
// R9: Done is read only and stays pending until the next start write.
// R10: Power select zero idles the converter; one powers and enables it.
// R11: Software sets power select at least one instruction before start.
// R12: Core wait mode neither powers down nor halts the converter.
// R13: Reset aborts conversion, loads control with 40h, masks the interrupt.
// R14: Each finished conversion stores its eight bit result.
// R15: A conversion takes typically 70 us with an 8 MHz oscillator; the code takes 480 cycles, 60 us.
// R16: Software configures at most one line as analog input at once.
// R17: End of conversion interrupt can wake the core from wait mode.
// R18: Result register is read only, result bits in positions 7 to 0.
// R19: Result resolves from most to least significant bit, one per step.
`timescale 1ns/10ps
`default_nettype none
`include "sac_defs.svh"

module sac_top
	import sac_pkg::*;
#(
	parameter int DIV       = `SAC_OSC_DIV,
	parameter int BIT_TICKS = `SAC_BIT_TICKS
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_n,
	input  wire logic [7:0] i_addr,
	input  wire logic       i_wr_en,
	input  wire logic       i_rd_en,
	input  wire logic [7:0] i_wdata,
	output var  logic [7:0] o_rdata,
	input  wire logic       i_cmp_above,
	input  wire logic       i_wait_mode,
	output var  logic [7:0] o_dac_trial,
	output var  logic       o_conv_power,
	output var  logic       o_irq_vec4,
	output var  logic       o_wake
);

	localparam logic [7:0] CTRL_RST = `SAC_CTRL_RST;

	sac_ifc ifc ();

	logic       irq_en_reg;
	logic       power_reg;
	logic       done_reg;
	logic       done_next;
	logic [7:0] rdata_reg;

	// Address decode and write strobes
	wire ctrl_hit = sac_hit(i_addr, `SAC_CTRL_OFF);
	wire res_hit  = sac_hit(i_addr, `SAC_RES_OFF);
	wire ctrl_wr  = i_wr_en && ctrl_hit;
	wire start_wr = ctrl_wr && i_wdata[`SAC_START_BIT]; // R2

	// Start only begins a conversion when power was already on; a same-write
	// power-up cannot start, the converter needs time to settle
	assign ifc.start = start_wr; // R5
	assign ifc.power = power_reg; // R10 R11
	assign ifc.cmp   = i_cmp_above;

	// Done flag: completion beats a start write in the same cycle
	assign done_next = ifc.done ? 1'b1 : (start_wr ? 1'b0 : done_reg); // R2 R3 R9

	// Control register view; start and unused bits read zero
	wire [7:0] ctrl_view = {irq_en_reg, done_reg, 1'b0, power_reg, 4'h0}; // R6 R8
	wire [7:0] rd_value  = ctrl_hit ? ctrl_view :
		(res_hit ? ifc.result : `SAC_ZERO8); // R18

	// Outputs; wait mode only gates the wake, never the converter
	assign o_rdata      = rdata_reg;
	assign o_dac_trial  = ifc.trial;
	assign o_conv_power = power_reg; // R10 R12
	assign o_irq_vec4   = irq_en_reg && done_reg; // R7
	assign o_wake       = o_irq_vec4 && i_wait_mode; // R17

	// Control register storage
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_en_reg <= CTRL_RST[`SAC_IRQ_EN_BIT]; // R13
			power_reg  <= CTRL_RST[`SAC_POWER_BIT]; // R13
			done_reg   <= CTRL_RST[`SAC_EOC_BIT]; // R13
		end else begin
			done_reg <= done_next;
			if (ctrl_wr) begin
				irq_en_reg <= i_wdata[`SAC_IRQ_EN_BIT]; // R8
				power_reg  <= i_wdata[`SAC_POWER_BIT]; // R8
			end
		end
	end

	// Read data registered one cycle after the strobe
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_reg <= `SAC_ZERO8;
		end else if (i_rd_en) begin
			rdata_reg <= rd_value;
		end
	end

	// Sequencer; start and power reach it through the carrier interface
	sac_seq #(
		.DIV       (DIV),
		.BIT_TICKS (BIT_TICKS)
	) u_seq (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.bus       (ifc.seq)
	);

	// All checks below share the one clock and pause while in reset
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	// Steps for the properties below; only s_ctrl_read serves two of them
	sequence s_finish;
		ifc.done && !start_wr;
	endsequence

	sequence s_no_start4;
		(!start_wr)[*4];
	endsequence

	sequence s_ctrl_read;
		i_rd_en && ctrl_hit;
	endsequence

	a_start_clears_done: assert property ( // R2
		(start_wr && !ifc.done) |=> !done_reg)
		else $error("start did not clear done");

	a_done_sets_flag: assert property ( // R3
		ifc.done |=> done_reg)
		else $error("done flag not set");

	a_single_shot: assert property ( // R4
		s_finish ##1 s_no_start4 |=> !ifc.busy)
		else $error("converter restarted alone");

	a_restart_fresh: assert property ( // R5 R19
		(start_wr && power_reg) |=> ifc.busy && (ifc.trial == `SAC_TRIAL_FIRST))
		else $error("start did not begin fresh conversion");

	a_start_reads_zero: assert property ( // R6
		s_ctrl_read |=> !o_rdata[`SAC_START_BIT])
		else $error("start bit read nonzero");

	a_ctrl_layout: assert property ( // R8
		s_ctrl_read |=> o_rdata == {$past(irq_en_reg), $past(done_reg), 1'b0,
			$past(power_reg), 4'h0})
		else $error("control layout wrong");

	a_irq_masked: assert property ( // R7
		!irq_en_reg |-> !o_irq_vec4)
		else $error("masked interrupt raised");

	a_irq_raised: assert property ( // R7
		(ifc.done && irq_en_reg && !ctrl_wr) |=> o_irq_vec4)
		else $error("interrupt not raised");

	a_done_pending: assert property ( // R9
		(done_reg && !start_wr) |=> done_reg)
		else $error("done cleared without start");

	a_power_idle: assert property ( // R10
		!power_reg |=> !ifc.busy)
		else $error("conversion runs unpowered");

	a_wait_runs_on: assert property ( // R12
		(ifc.busy && power_reg && !ctrl_wr && !ifc.done && i_wait_mode) |=> ifc.busy || ifc.done)
		else $error("wait mode halted conversion");

	a_result_read: assert property ( // R14 R18
		(i_rd_en && res_hit) |=> o_rdata == $past(ifc.result))
		else $error("result read wrong");

	a_wake_in_wait: assert property ( // R17
		$rose(o_irq_vec4) && i_wait_mode |-> o_wake)
		else $error("no wake from wait");

	// Register map and idle behaviour
	a_done_read_only: assert property ( // R9
		(ctrl_wr && !start_wr && !ifc.done) |=> done_reg == $past(done_reg))
		else $error("done flag written by software");

	a_write_fields: assert property ( // R8
		ctrl_wr |=> (irq_en_reg == $past(i_wdata[`SAC_IRQ_EN_BIT]))
			&& (power_reg == $past(i_wdata[`SAC_POWER_BIT])))
		else $error("control write fields wrong");

	a_unpowered_start: assert property ( // R10 R11
		(start_wr && !power_reg) |=> !ifc.busy)
		else $error("start ran without power");

	a_power_abort: assert property ( // R10
		(ifc.busy && !power_reg && !start_wr) |=> !ifc.done)
		else $error("aborted conversion flagged done");

	a_idle_stays: assert property ( // R4
		(!ifc.busy && !start_wr) |=> !ifc.busy)
		else $error("idle converter started alone");

	a_result_hold: assert property ( // R14
		$changed(ifc.result) |-> ifc.done)
		else $error("result changed without completion");

	a_result_no_write: assert property ( // R18
		(i_wr_en && res_hit && !ifc.busy) |=> $stable(ifc.result))
		else $error("result register written");

	a_read_stands: assert property ( // R18
		!i_rd_en |=> $stable(o_rdata))
		else $error("read data changed without a read");

endmodule : sac_top

`default_nettype wire

// >>> dv/sac_top_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "sac_defs.svh"
// One comparison, counted; case equality so an unknown never matches
`define chk(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, (got), (exp)); end end

module sac_top_test;
	localparam int DIV   = 2;
	localparam int BT    = 1;
	localparam int CONV  = 8 * BT * DIV;
	localparam int LIMIT = 5000;

	typedef struct {
		logic [7:0] wd;
		logic [7:0] rd;
		logic       pwr;
		logic       irq;
	} sac_row_t;

	logic       i_ref_clk;
	logic       i_rst_n;
	logic [7:0] i_addr;
	logic       i_wr_en;
	logic       i_rd_en;
	logic [7:0] i_wdata;
	logic       i_wait_mode;
	logic [7:0] target;
	wire  [7:0] rdata;
	wire  [7:0] dac_trial;
	wire        conv_power;
	wire        irq;
	wire        wake;
	int         failures;
	int         comparisons;
	int         cycles;
	int         n;
	logic [7:0] d;
	logic       seen;
	sac_row_t   rows [5];

	// Analog side: comparator says input at or above the trial code
	sac_top #(.DIV(DIV), .BIT_TICKS(BT)) i_sac_top (
		.i_ref_clk   (i_ref_clk),
		.i_rst_n     (i_rst_n),
		.i_addr      (i_addr),
		.i_wr_en     (i_wr_en),
		.i_rd_en     (i_rd_en),
		.i_wdata     (i_wdata),
		.o_rdata     (rdata),
		.i_cmp_above (target >= dac_trial),
		.i_wait_mode (i_wait_mode),
		.o_dac_trial (dac_trial),
		.o_conv_power(conv_power),
		.o_irq_vec4  (irq),
		.o_wake      (wake)
	);

	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	// Hang guard, limit well above the whole sequence
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			failures++;
			wrap_up();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_ref_clk);
		i_addr  <= a;
		i_wdata <= v;
		i_wr_en <= 1'b1;
		@(posedge i_ref_clk);
		i_wr_en <= 1'b0;
	endtask : wr

	// Read data lands one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge i_ref_clk);
		i_addr  <= a;
		i_rd_en <= 1'b1;
		@(posedge i_ref_clk);
		i_rd_en <= 1'b0;
		#1 v = rdata;
	endtask : rd

	// Start with the given control byte, count cycles until the request
	task automatic conv(input logic [7:0] val, input logic [7:0] ctl);
		target <= val;
		wr(`SAC_CTRL_OFF, ctl);
		n = 0;
		while (irq !== 1'b1 && n < 100) begin
			@(posedge i_ref_clk);
			#1 n++;
		end
	endtask : conv

	// Run quietly for a while, noting any interrupt request
	task automatic idle(input int c);
		seen = 1'b0;
		repeat (c) begin
			@(posedge i_ref_clk);
			#1 seen = seen | (irq === 1'b1);
		end
	endtask : idle

	task automatic wrap_up;
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	initial begin
		rows = '{'{8'h00, 8'h40, 1'b0, 1'b0}, '{8'h4F, 8'h40, 1'b0, 1'b0},
			'{8'h10, 8'h50, 1'b1, 1'b0}, '{8'h9F, 8'hD0, 1'b1, 1'b1},
			'{8'h80, 8'hC0, 1'b0, 1'b1}};
		i_rst_n = 1'b0;
		i_addr = 8'h00;
		i_wr_en = 1'b0;
		i_rd_en = 1'b0;
		i_wdata = 8'h00;
		i_wait_mode = 1'b0;
		target = 8'h00;
		repeat (8) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		rd(`SAC_CTRL_OFF, d);
		`chk(d, 8'h40)
		`chk(irq, 1'b0)
		rd(`SAC_RES_OFF, d);
		`chk(d, 8'h00)
		rd(8'h55, d);
		`chk(d, 8'h00)
		// Register table rows: fixed bits, power and interrupt mask
		foreach (rows[i]) begin
			wr(`SAC_CTRL_OFF, rows[i].wd);
			rd(`SAC_CTRL_OFF, d);
			`chk(d, rows[i].rd)
			`chk(conv_power, rows[i].pwr)
			`chk(irq, rows[i].irq)
		end
		// Full conversion in wait mode, enabled interrupt
		wr(`SAC_CTRL_OFF, 8'h90);
		i_wait_mode <= 1'b1;
		target <= 8'hA5;
		wr(`SAC_CTRL_OFF, 8'hB0);
		#1 `chk(irq, 1'b0)
		`chk(dac_trial, 8'h80)
		rd(`SAC_CTRL_OFF, d);
		`chk(d, 8'h90)
		n = 0;
		while (irq !== 1'b1 && n < 100) begin
			@(posedge i_ref_clk);
			#1 n++;
		end
		`chk(n inside {[CONV - 6 : CONV + 2]}, 1'b1)
		`chk(wake, 1'b1)
		`chk(dac_trial, 8'hA5)
		rd(`SAC_RES_OFF, d);
		`chk(d, 8'hA5)
		rd(`SAC_CTRL_OFF, d);
		`chk(d, 8'hD0)
		// Single shot: new input level does not change the stored result
		target <= 8'h11;
		idle(40);
		wr(`SAC_RES_OFF, 8'hFF);
		rd(`SAC_RES_OFF, d);
		`chk(d, 8'hA5)
		`chk(conv_power, 1'b1)
		// Restart in mid-run discards the first search
		i_wait_mode <= 1'b0;
		wr(`SAC_CTRL_OFF, 8'hB0);
		repeat (6) @(posedge i_ref_clk);
		conv(8'h3C, 8'hB0);
		`chk(n inside {[CONV - 2 : CONV + 2]}, 1'b1)
		`chk(wake, 1'b0)
		rd(`SAC_RES_OFF, d);
		`chk(d, 8'h3C)
		// Masked: conversion completes, no request
		target <= 8'h01;
		wr(`SAC_CTRL_OFF, 8'h30);
		idle(40);
		`chk(seen, 1'b0)
		rd(`SAC_CTRL_OFF, d);
		`chk(d, 8'h50)
		rd(`SAC_RES_OFF, d);
		`chk(d, 8'h01)
		// Power dropped in mid-run: conversion aborted, done stays clear
		wr(`SAC_CTRL_OFF, 8'h30);
		wr(`SAC_CTRL_OFF, 8'h00);
		idle(40);
		rd(`SAC_CTRL_OFF, d);
		`chk(d, 8'h00)
		// Start with power off: done cleared, nothing runs
		wr(`SAC_CTRL_OFF, 8'h80);
		wr(`SAC_CTRL_OFF, 8'hA0);
		idle(40);
		`chk(seen, 1'b0)
		rd(`SAC_CTRL_OFF, d);
		`chk(d, 8'h80)
		// Reset in mid-conversion
		wr(`SAC_CTRL_OFF, 8'h90);
		wr(`SAC_CTRL_OFF, 8'hB0);
		repeat (4) @(posedge i_ref_clk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		idle(40);
		`chk(seen, 1'b0)
		`chk(conv_power, 1'b0)
		rd(`SAC_CTRL_OFF, d);
		`chk(d, 8'h40)
		wrap_up();
	end
endmodule : sac_top_test

`default_nettype wire
